// file: verilog/fstat_defs.svh
// Overview of operation
// - Update mode loads each measurement as the offset for the next one.
// - Offset mode: off, add offset, subtract offset, or ppm deviation.
// - Statistics: off, mean, max, min, peak-to-peak equal to max minus min.
// - Discrete mean is the average of the N samples since the last result.
// - Overlap mean is the moving average of the last N samples, once N exist.
// - Discrete max and min cover samples 1..N of the block, then restart.
// - Overlap max and min cover the window n-N+1..n, only once n reaches N.
// - Discrete mode emits one result per N new samples, none between.
// - Overlap mode emits after N samples, then after every further sample.
// - Sample setting n is 1..6; overlap window is two to the n.
// - Discrete block sizes are 16, 128, 1024, 16384, 131072, 1048576.
// - Restart clears the sample count; statistics begin from the first sample.
// - With limits on, every measurement gets a pass or fail judgment.
// - One enable bit switches limit checking on or off.
// - Limits range from 0 Hz to the maximum frequency in 1 Hz steps.
// - Judgment output holds until the next judgment completes or an enable bit clears it.
// - Pass is high inside the range, low outside, low when disabled.
// - Indicate bit enables the above or below range direction flags.
`ifndef FSTAT_DEFS_SVH
`define FSTAT_DEFS_SVH

// Widths
`define FS_HW 36
`define FS_VW 40
`define FS_SW 60
`define FS_CW 20
`define FS_MW 6
`define FS_DEPTH 64
`define FS_PAD 4'h0

// Frequency range and reset values
`define FS_FMAX 36'h9_502F_9000
`define FS_UPR_RST `FS_FMAX
`define FS_N_RST 3'h1
`define FS_N_MIN 3'h1
`define FS_N_MAX 3'h6
`define FS_PPM 64'h0000_0000_000F_4240
`define FS_DSH_TAB {5'h14, 5'h11, 5'h0E, 5'h0A, 5'h07, 5'h04}
`define FS_DIV_STEPS 7'h40

// Register byte addresses
`define FS_A_CTRL 6'h00
`define FS_A_OFS_LO 6'h04
`define FS_A_OFS_HI 6'h08
`define FS_A_UPR_LO 6'h0C
`define FS_A_UPR_HI 6'h10
`define FS_A_LWR_LO 6'h14
`define FS_A_LWR_HI 6'h18
`define FS_A_RES_LO 6'h1C
`define FS_A_RES_HI 6'h20
`define FS_A_STAT 6'h24

// Control register fields
`define FS_C_OM 1:0
`define FS_C_UPD 2
`define FS_C_SM 5:3
`define FS_C_OVL 6
`define FS_C_N 9:7
`define FS_C_LIM 10
`define FS_C_IND 11
`define FS_C_RST 31

`endif

// file: verilog/fstat_pkg.sv
`include "fstat_defs.svh"
package fstat_pkg;

   typedef enum logic [1:0] {OM_OFF, OM_PLUS, OM_MINUS, OM_PPM} fstat_omode_t;
   typedef enum logic [2:0] {SM_OFF, SM_MEAN, SM_MAX, SM_MIN, SM_PP} fstat_smode_t;
   typedef enum logic [2:0] {S_IDLE, S_DIV, S_PROC, S_OLD, S_SCAN} fstat_state_t;

   typedef struct packed {
      fstat_state_t st;
      logic waitrq;
      logic [31:0] rdata;
      logic [1:0] omode;
      logic upd;
      logic [2:0] smode;
      logic ovl;
      logic [2:0] nsel;
      logic lim_en;
      logic ind;
      logic [`FS_HW-1:0] ofs, upr, lwr, m, den;
      logic [63:0] dnum;
      logic signed [`FS_VW-1:0] x, res, mx, mn;
      logic signed [`FS_SW-1:0] sum;
      logic [`FS_CW-1:0] cnt;
      logic [6:0] fill, scnt;
      logic [`FS_MW-1:0] wptr, base, raddr;
      logic neg, res_v, pass, above, below, rdy, dstart, mwe;
   } fstat_top_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic [6:0] cnt;
      logic [`FS_HW-1:0] rem, den;
      logic [63:0] quo;
   } fstat_div_t;

   typedef struct packed {
      logic [`FS_DEPTH-1:0][`FS_VW-1:0] ram;
      logic [`FS_VW-1:0] rdata;
   } fstat_mem_t;

endpackage

// file: verilog/fstat_if.sv
`timescale 1ns/100ps
`include "fstat_defs.svh"
interface fstat_div_if;
   logic start;
   logic [63:0] num;
   logic [`FS_HW-1:0] den;
   logic done;
   logic [63:0] quo;
   modport master (output start, output num, output den, input done, input quo);
   modport slave (input start, input num, input den, output done, output quo);
endinterface

interface fstat_mem_if;
   logic we;
   logic [`FS_MW-1:0] waddr;
   logic [`FS_MW-1:0] raddr;
   logic [`FS_VW-1:0] wdata;
   logic [`FS_VW-1:0] rdata;
   modport master (output we, output waddr, output raddr, output wdata, input rdata);
   modport slave (input we, input waddr, input raddr, input wdata, output rdata);
endinterface

// file: verilog/fstat_div.sv
`timescale 1ns/100ps
`include "fstat_defs.svh"
module fstat_div
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Divide request and answer
   fstat_div_if.slave d
);

   fstat_pkg::fstat_div_t q, n;

   // Restoring division, one quotient bit per clock; a new start aborts a running one
   always_comb
   begin
      logic [`FS_HW:0] r;
      r = '0;
      n = q;
      n.done = 1'b0;
      if (d.start)
      begin
         n.quo = d.num;
         n.rem = '0;
         n.den = d.den;
         n.cnt = `FS_DIV_STEPS;
         n.busy = 1'b1;
      end
      else if (q.busy)
      begin
         r = {q.rem, q.quo[63]};
         n.quo = {q.quo[62:0], 1'b0};
         if (r >= {1'b0, q.den})
         begin
            r = r - {1'b0, q.den};
            n.quo[0] = 1'b1;
         end
         n.rem = r[`FS_HW-1:0];
         n.cnt = q.cnt - 7'h01;
         if (q.cnt == 7'h01)
         begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign d.done = q.done;
   assign d.quo = q.quo;

endmodule

// file: verilog/fstat_mem.sv
`timescale 1ns/100ps
`include "fstat_defs.svh"
module fstat_mem
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Window storage port
   fstat_mem_if.slave p
);

   fstat_pkg::fstat_mem_t q, n;

   // Read returns the old word when the same slot is written in that cycle
   always_comb
   begin
      n = q;
      if (p.we)
      begin
         n.ram[p.waddr] = p.wdata;
      end
      n.rdata = q.ram[p.raddr];
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign p.rdata = q.rdata;

endmodule

// file: verilog/fstat_top.sv
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`include "fstat_defs.svh"
module fstat_top
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Avalon-MM register slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Measurement stream
   input wire logic meas_valid,
   input wire logic [`FS_HW-1:0] meas_hz,
   output logic meas_ready,
   // Results
   output logic res_valid,
   output logic [`FS_VW-1:0] res_value,
   output logic lim_pass,
   output logic lim_above,
   output logic lim_below
);

   fstat_pkg::fstat_top_t q, n;

   fstat_div_if div_if();
   fstat_mem_if mem_if();

   fstat_div u_div
   (
      .mclk(mclk),
      .rst(rst),
      .d(div_if.slave)
   );

   fstat_mem u_mem
   (
      .mclk(mclk),
      .rst(rst),
      .p(mem_if.slave)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************

   function automatic logic [31:0] be_mrg(input logic [31:0] o, input logic [31:0] w,
      input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = w[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Byte-enabled write into a 36-bit register held as a low and a high word
   function automatic logic [`FS_HW-1:0] wr36(input logic [`FS_HW-1:0] o, input logic hi,
      input logic [31:0] w, input logic [3:0] be);
      logic [63:0] t;
      t = {28'h0, o};
      if (hi)
      begin
         t[63:32] = be_mrg(t[63:32], w, be);
      end
      else
      begin
         t[31:0] = be_mrg(t[31:0], w, be);
      end
      return t[`FS_HW-1:0];
   endfunction

   // Stored values are kept as written; use clips them to the top of the range
   function automatic logic [`FS_HW-1:0] lim(input logic [`FS_HW-1:0] v);
      lim = (v > `FS_FMAX) ? `FS_FMAX : v;
   endfunction

   function automatic logic [4:0] dsh(input logic [2:0] k);
      logic [29:0] tab;
      logic [2:0] i;
      tab = `FS_DSH_TAB;
      i = k - `FS_N_MIN;
      dsh = tab[i*5 +: 5];
   endfunction

   function automatic logic signed [`FS_VW-1:0] pick(input logic [2:0] sm,
      input logic signed [`FS_SW-1:0] s, input logic [4:0] sh,
      input logic signed [`FS_VW-1:0] hi, input logic signed [`FS_VW-1:0] lo);
      logic signed [`FS_SW-1:0] mean;
      // Power-of-two counts make the mean a plain arithmetic shift
      mean = s >>> sh;
      case (sm)
         fstat_pkg::SM_MEAN: pick = mean[`FS_VW-1:0];
         fstat_pkg::SM_MAX: pick = hi;
         fstat_pkg::SM_MIN: pick = lo;
         default: pick = hi - lo;
      endcase
   endfunction

   // ****************************************************************
   // Next-state logic
   // ****************************************************************

   always_comb
   begin
      logic [31:0] ci;
      logic [2:0] nw;
      logic signed [`FS_VW-1:0] dev, mz, oz, v, hi, lo;
      logic [`FS_HW-1:0] of, up, lw;
      logic [63:0] mag;
      logic [6:0] nov;
      logic [4:0] sh;
      logic [`FS_CW-1:0] dlast;
      logic rstrt, son;
      n = q;
      n.res_v = 1'b0;
      n.dstart = 1'b0;
      n.mwe = 1'b0;
      n.waitrq = 1'b1;
      rstrt = 1'b0;
      nw = q.nsel;
      v = '0;
      hi = '0;
      lo = '0;
      mag = '0;
      of = lim(q.ofs);
      up = lim(q.upr);
      lw = lim(q.lwr);
      mz = $signed({`FS_PAD, meas_hz});
      oz = $signed({`FS_PAD, of});
      dev = mz - oz;
      ci = '0;
      ci[`FS_C_OM] = q.omode;
      ci[`FS_C_UPD] = q.upd;
      ci[`FS_C_SM] = q.smode;
      ci[`FS_C_OVL] = q.ovl;
      ci[`FS_C_N] = q.nsel;
      ci[`FS_C_LIM] = q.lim_en;
      ci[`FS_C_IND] = q.ind;
      nov = 7'h01 << q.nsel;
      sh = q.ovl ? {2'h0, q.nsel} : dsh(q.nsel);
      dlast = (`FS_CW'(1) << sh) - `FS_CW'(1);
      son = (q.smode >= fstat_pkg::SM_MEAN) && (q.smode <= fstat_pkg::SM_PP);

      // ****************************************************************
      // Register access: every access answers on the second cycle
      // ****************************************************************
      if ((avs_read | avs_write) & q.waitrq)
      begin
         n.waitrq = 1'b0;
         if (avs_write)
         begin
            case (avs_address)
               `FS_A_CTRL:
               begin
                  ci = be_mrg(ci, avs_writedata, avs_byteenable);
                  nw = ci[`FS_C_N];
                  if (nw < `FS_N_MIN)
                  begin
                     nw = `FS_N_MIN;
                  end
                  if (nw > `FS_N_MAX)
                  begin
                     nw = `FS_N_MAX;
                  end
                  n.omode = ci[`FS_C_OM];
                  n.upd = ci[`FS_C_UPD];
                  n.smode = ci[`FS_C_SM];
                  n.ovl = ci[`FS_C_OVL];
                  n.nsel = nw;
                  n.lim_en = ci[`FS_C_LIM];
                  n.ind = ci[`FS_C_IND];
                  rstrt = ci[`FS_C_RST];
                  if ((n.smode != q.smode) || (n.ovl != q.ovl) || (nw != q.nsel))
                  begin
                     rstrt = 1'b1;
                  end
               end
               `FS_A_OFS_LO: n.ofs = wr36(q.ofs, 1'b0, avs_writedata, avs_byteenable);
               `FS_A_OFS_HI: n.ofs = wr36(q.ofs, 1'b1, avs_writedata, avs_byteenable);
               `FS_A_UPR_LO: n.upr = wr36(q.upr, 1'b0, avs_writedata, avs_byteenable);
               `FS_A_UPR_HI: n.upr = wr36(q.upr, 1'b1, avs_writedata, avs_byteenable);
               `FS_A_LWR_LO: n.lwr = wr36(q.lwr, 1'b0, avs_writedata, avs_byteenable);
               `FS_A_LWR_HI: n.lwr = wr36(q.lwr, 1'b1, avs_writedata, avs_byteenable);
               default: ;
            endcase
         end
         else
         begin
            case (avs_address)
               `FS_A_CTRL: n.rdata = ci;
               `FS_A_OFS_LO: n.rdata = q.ofs[31:0];
               `FS_A_OFS_HI: n.rdata = {28'h0, q.ofs[`FS_HW-1:32]};
               `FS_A_UPR_LO: n.rdata = q.upr[31:0];
               `FS_A_UPR_HI: n.rdata = {28'h0, q.upr[`FS_HW-1:32]};
               `FS_A_LWR_LO: n.rdata = q.lwr[31:0];
               `FS_A_LWR_HI: n.rdata = {28'h0, q.lwr[`FS_HW-1:32]};
               `FS_A_RES_LO: n.rdata = q.res[31:0];
               `FS_A_RES_HI: n.rdata = {{24{q.res[`FS_VW-1]}}, q.res[`FS_VW-1:32]};
               `FS_A_STAT: n.rdata = {21'h0, q.fill, ~q.rdy, q.above, q.below, q.pass};
               default: n.rdata = '0;
            endcase
         end
      end

      // ****************************************************************
      // Measurement processing
      // ****************************************************************
      unique case (q.st)
         fstat_pkg::S_IDLE:
         begin
            if (meas_valid & q.rdy)
            begin
               n.m = meas_hz;
               // Judgment is taken only here; clearing lim_en zeroes the held one, clearing ind its above and below flags
               n.pass = (meas_hz >= lw) && (meas_hz <= up);
               n.above = meas_hz > up;
               n.below = meas_hz < lw;
               n.st = fstat_pkg::S_PROC;
               case (q.omode)
                  fstat_pkg::OM_OFF: n.x = mz;
                  fstat_pkg::OM_PLUS: n.x = mz + oz;
                  fstat_pkg::OM_MINUS: n.x = dev;
                  default:
                  begin
                     // A zero reference has no defined ppm figure; it reports zero
                     if (of == '0)
                     begin
                        n.x = '0;
                     end
                     else
                     begin
                        n.neg = dev[`FS_VW-1];
                        mag = {24'h0, (dev[`FS_VW-1] ? -dev : dev)};
                        n.dnum = mag * `FS_PPM;
                        n.den = of;
                        n.dstart = 1'b1;
                        n.st = fstat_pkg::S_DIV;
                     end
                  end
               endcase
            end
         end
         fstat_pkg::S_DIV:
         begin
            if (div_if.done)
            begin
               v = $signed(div_if.quo[`FS_VW-1:0]);
               n.x = q.neg ? -v : v;
               n.st = fstat_pkg::S_PROC;
            end
         end
         fstat_pkg::S_PROC:
         begin
            // Update wins over a software write of the offset in the same cycle
            if (q.upd)
            begin
               n.ofs = q.m;
            end
            if (!son)
            begin
               n.res = q.x;
               n.res_v = 1'b1;
               n.st = fstat_pkg::S_IDLE;
            end
            else if (!q.ovl)
            begin
               hi = ((q.cnt == '0) || (q.x > q.mx)) ? q.x : q.mx;
               lo = ((q.cnt == '0) || (q.x < q.mn)) ? q.x : q.mn;
               n.mx = hi;
               n.mn = lo;
               n.sum = ((q.cnt == '0) ? '0 : q.sum) + `FS_SW'(q.x);
               n.st = fstat_pkg::S_IDLE;
               if (q.cnt == dlast)
               begin
                  n.res = pick(q.smode, n.sum, sh, hi, lo);
                  n.res_v = 1'b1;
                  n.cnt = '0;
               end
               else
               begin
                  n.cnt = q.cnt + `FS_CW'(1);
               end
            end
            else
            begin
               // Fetch the sample about to leave the window
               n.raddr = q.wptr - nov[`FS_MW-1:0];
               n.st = fstat_pkg::S_OLD;
            end
         end
         fstat_pkg::S_OLD:
         begin
            v = $signed(mem_if.rdata);
            n.sum = q.sum + `FS_SW'(q.x) - ((q.fill >= nov) ? `FS_SW'(v) : '0);
            n.mwe = 1'b1;
            n.wptr = q.wptr + `FS_MW'(1);
            n.fill = (q.fill >= nov) ? q.fill : q.fill + 7'h01;
            n.st = fstat_pkg::S_IDLE;
            if (n.fill >= nov)
            begin
               n.base = q.wptr - nov[`FS_MW-1:0] + `FS_MW'(1);
               n.raddr = n.base;
               n.scnt = '0;
               n.st = fstat_pkg::S_SCAN;
            end
         end
         fstat_pkg::S_SCAN:
         begin
            // Rescan of the whole window; costs N cycles but needs no sorted store
            v = $signed(mem_if.rdata);
            hi = ((q.scnt == '0) || (v > q.mx)) ? v : q.mx;
            lo = ((q.scnt == '0) || (v < q.mn)) ? v : q.mn;
            n.mx = hi;
            n.mn = lo;
            if (q.scnt == (nov - 7'h01))
            begin
               n.res = pick(q.smode, q.sum, sh, hi, lo);
               n.res_v = 1'b1;
               n.st = fstat_pkg::S_IDLE;
            end
            else
            begin
               n.scnt = q.scnt + 7'h01;
               n.raddr = q.base + n.scnt[`FS_MW-1:0];
            end
         end
      endcase

      if (rstrt)
      begin
         n.cnt = '0;
         n.fill = '0;
         n.wptr = '0;
         n.sum = '0;
         n.st = fstat_pkg::S_IDLE;
      end
      if (!n.lim_en)
      begin
         n.pass = 1'b0;
         n.above = 1'b0;
         n.below = 1'b0;
      end
      if (!n.ind)
      begin
         n.above = 1'b0;
         n.below = 1'b0;
      end
      n.rdy = (n.st == fstat_pkg::S_IDLE);
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         q <= '0;
         q.st <= fstat_pkg::S_IDLE;
         q.waitrq <= 1'b1;
         q.upr <= `FS_UPR_RST;
         q.nsel <= `FS_N_RST;
         q.rdy <= 1'b1;
      end
      else
      begin
         q <= n;
      end
   end

   assign div_if.start = q.dstart;
   assign div_if.num = q.dnum;
   assign div_if.den = q.den;
   assign mem_if.we = n.mwe;
   assign mem_if.waddr = q.wptr;
   assign mem_if.wdata = q.x;
   assign mem_if.raddr = n.raddr;

   assign avs_readdata = q.rdata;
   assign avs_waitrequest = q.waitrq;
   assign meas_ready = q.rdy;
   assign res_valid = q.res_v;
   assign res_value = q.res;
   assign lim_pass = q.pass;
   assign lim_above = q.above;
   assign lim_below = q.below;

endmodule

// file: verification/fstat_top_props.sv
`timescale 1ns/100ps
`include "fstat_defs.svh"
module fstat_top_props
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // Measurement stream
   input wire logic meas_valid,
   input wire logic meas_ready,
   // Results
   input wire logic res_valid,
   input wire logic [`FS_VW-1:0] res_value,
   input wire logic lim_pass,
   input wire logic lim_above,
   input wire logic lim_below
);
   logic took;
   assign took = meas_valid && meas_ready;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // ****
   // Handshakes
   // ****
   bus_answer_a:
   assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late or long");
   bus_idle_a:
   assert property (!avs_read && !avs_write |=> avs_waitrequest) else $error("idle answer");
   take_block_a:
   assert property (took |=> !meas_ready) else $error("ready kept after take");
   ready_back_a:
   assert property ($fell(meas_ready) |-> ##[1:400] meas_ready) else $error("ready lost");
   // ****
   // Results and judgment
   // ****
   res_pulse_a:
   assert property (res_valid |=> !res_valid) else $error("result pulse too long");
   res_hold_a:
   assert property (!res_valid && !$past(rst) |-> $stable(res_value)) else $error("result moved");
   judge_hold_a:
   assert property (!$past(took) && !$past(took, 2) && !$past(avs_write) && !$past(avs_write, 2)
      && !$past(avs_write, 3) && !$past(rst) |-> $stable({lim_pass, lim_above, lim_below}))
      else $error("judgment moved without cause");
   above_excl_a:
   assert property (lim_above |-> !lim_pass && !lim_below) else $error("above with pass");
   below_excl_a:
   assert property (lim_below |-> !lim_pass) else $error("below with pass");
endmodule
bind fstat_top fstat_top_props chk_u
(
   .mclk(mclk),
   .rst(rst),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest),
   .meas_valid(meas_valid),
   .meas_ready(meas_ready),
   .res_valid(res_valid),
   .res_value(res_value),
   .lim_pass(lim_pass),
   .lim_above(lim_above),
   .lim_below(lim_below)
);

// file: verification/fstat_meas_eng.sv
`timescale 1ns/100ps
`include "fstat_defs.svh"
module fstat_meas_eng
(
   // Clock
   input wire logic mclk,
   // Idle cycles after each measurement
   input wire logic [3:0] gap,
   // Measurement stream
   output logic meas_valid,
   output logic [`FS_HW-1:0] meas_hz,
   input wire logic meas_ready
);
   logic [`FS_HW-1:0] q[$];
   initial
   begin
      meas_valid = 1'h0;
      meas_hz = '0;
      forever
      begin
         @(posedge mclk);
         if (q.size() != 0)
         begin
            meas_valid <= 1'h1;
            meas_hz <= q.pop_front();
            do
               @(posedge mclk);
            while (meas_ready !== 1'h1);
            meas_valid <= 1'h0;
            // Released value is scrambled so nothing leans on a stale reading
            meas_hz <= ~meas_hz;
            repeat (gap) @(posedge mclk);
         end
      end
   end
endmodule

// file: verification/fstat_top_tb.sv
`timescale 1ns/100ps
`include "fstat_defs.svh"
module fstat_top_tb;
   typedef struct packed {logic [11:0] c; logic [35:0] o, m; logic [39:0] r; logic [2:0] l;}
      fstat_row_t;
   logic mclk, rst, avs_read, avs_write, avs_waitrequest, meas_valid, meas_ready;
   logic res_valid, lim_pass, lim_above, lim_below;
   logic [3:0] gap;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd, lo;
   logic [`FS_HW-1:0] meas_hz;
   logic [`FS_VW-1:0] res_value;
   logic [39:0] resq[$];
   int err_count, num_checks, i;
   // Control, offset, measurement, result, {above, below, pass}
   fstat_row_t rows[11] = '{
      '{12'hC00, 36'h0, 36'h5DC, 40'h5DC, 3'h1},
      '{12'hC01, 36'h64, 36'h7D0, 40'h834, 3'h1},
      '{12'hC02, 36'h64, 36'h3E8, 40'h384, 3'h1},
      '{12'hC03, 36'h3E8, 36'h3E9, 40'h3E8, 3'h1},
      '{12'hC03, 36'h7D0, 36'h3E7, 40'hFF_FFF8_5CEC, 3'h2},
      '{12'hC00, 36'h0, 36'h7D1, 40'h7D1, 3'h4},
      '{12'hC06, 36'h0, 36'h3E8, 40'h3E8, 3'h1},
      '{12'hC06, 36'h0, 36'h514, 40'h12C, 3'h1},
      '{12'hC06, 36'h0, 36'h4E2, 40'hFF_FFFF_FFCE, 3'h1},
      '{12'h400, 36'h0, 36'h9C4, 40'h9C4, 3'h0},
      '{12'h000, 36'h0, 36'h5DC, 40'h5DC, 3'h0}};

   fstat_top dut_u (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .meas_valid(meas_valid), .meas_hz(meas_hz), .meas_ready(meas_ready),
      .res_valid(res_valid), .res_value(res_value), .lim_pass(lim_pass),
      .lim_above(lim_above), .lim_below(lim_below));
   fstat_meas_eng m_u (.mclk(mclk), .gap(gap), .meas_valid(meas_valid), .meas_hz(meas_hz),
      .meas_ready(meas_ready));

   initial
   begin
      mclk = 1'h0;
      forever #2.5 mclk = ~mclk;
   end

   always @(posedge mclk)
      if (res_valid === 1'h1)
         resq.push_back(res_value);

   // ****
   // Tasks
   // ****
   task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      // Only the watchdog ends a wait that never gets its answer
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      @(posedge mclk);
   endtask

   task automatic drain(input int n);
      int t;
      t = 0;
      while ((m_u.q.size() != 0 || resq.size() < n) && t < 900)
      begin
         @(posedge mclk);
         t++;
      end
      chk("drain", 40'h0, 40'(t == 900));
      repeat (80) @(posedge mclk);
   endtask

   task automatic stat(input logic [2:0] sm, input logic ov);
      int nw, k, j;
      logic signed [39:0] s[$], mx, mn, sum;
      logic [39:0] e[$];
      logic [31:0] c;
      nw = ov ? 4 : 16;
      c = {22'h0, ov ? 3'h2 : 3'h1, ov, sm, 3'h0};
      // Odd modes test a restart, even ones a mode change over leftover samples
      if (sm[0])
         bus(1'h1, `FS_A_CTRL, c);
      repeat (3) m_u.q.push_back(36'hEA60);
      drain(0);
      bus(1'h1, `FS_A_CTRL, c | {sm[0], 31'h0});
      resq = {};
      for (k = 0; k < nw + 4; k++)
      begin
         s.push_back(40'h3E8 + 40'((k * 7 % 11) * 10));
         m_u.q.push_back(s[k][35:0]);
      end
      for (k = nw - 1; k < nw + 4; k += ov ? 1 : nw)
      begin
         {mx, mn, sum} = {s[k], s[k], 40'h0};
         for (j = k - nw + 1; j <= k; j++)
         begin
            sum += s[j];
            mx = s[j] > mx ? s[j] : mx;
            mn = s[j] < mn ? s[j] : mn;
         end
         e.push_back(sm == 3'h1 ? sum / nw : sm == 3'h2 ? mx : sm == 3'h3 ? mn : mx - mn);
      end
      drain(e.size());
      chk("count", 40'(e.size()), 40'(resq.size()));
      foreach (e[x]) chk("stat", e[x], resq[x]);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ****
   // Sequence
   // ****
   initial
   begin
      {rst, gap} = {1'h1, 4'h0};
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      repeat (3) @(posedge mclk);
      rst <= 1'h0;
      @(posedge mclk);
      bus(1'h0, `FS_A_UPR_LO, 32'h0);
      lo = rd;
      bus(1'h0, `FS_A_UPR_HI, 32'h0);
      chk("upper", {4'h0, `FS_FMAX}, {rd[7:0], lo});
      bus(1'h0, `FS_A_CTRL, 32'h0);
      chk("ctrl", 40'h80, {8'h0, rd});
      bus(1'h1, `FS_A_CTRL, 32'h380);
      bus(1'h0, `FS_A_CTRL, 32'h0);
      chk("clamp", 40'h300, {8'h0, rd});
      bus(1'h1, 6'h28, 32'hFFFF_FFFF);
      bus(1'h0, 6'h28, 32'h0);
      chk("unmapped", 40'h0, {8'h0, rd});
      bus(1'h1, `FS_A_LWR_LO, 32'h3E8);
      bus(1'h1, `FS_A_UPR_LO, 32'h7D0);
      bus(1'h1, `FS_A_UPR_HI, 32'h0);
      bus(1'h0, `FS_A_LWR_LO, 32'h0);
      chk("lower", 40'h3E8, {8'h0, rd});
      $display("test registers done");
      foreach (rows[r])
      begin
         bus(1'h1, `FS_A_CTRL, {20'h0, rows[r].c} | 32'h80);
         if (!rows[r].c[2])
            bus(1'h1, `FS_A_OFS_LO, rows[r].o[31:0]);
         resq = {};
         m_u.q.push_back(rows[r].m);
         drain(1);
         chk("result", rows[r].r, resq[0]);
         chk("judge", 40'(rows[r].l), {37'h0, lim_above, lim_below, lim_pass});
         $display("test row %0d done", r);
      end
      for (i = 0; i < 8; i++)
      begin
         gap <= 4'(i);
         stat(3'(i % 4 + 1), i[2]);
         $display("test stat %0d done", i);
      end
      rst <= 1'h1;
      repeat (3) @(posedge mclk);
      rst <= 1'h0;
      @(posedge mclk);
      chk("reset result", 40'h0, res_value);
      chk("reset ready", 40'h1, {39'h0, meas_ready});
      bus(1'h0, `FS_A_CTRL, 32'h0);
      chk("reset ctrl", 40'h80, {8'h0, rd});
      $display("test reset done");
      results();
   end

   initial
   begin
      repeat (30000) @(posedge mclk);
      err_count++;
      results();
   end
endmodule
